/* hdl/branch_clock_regs.svh */
// Register offsets, field positions and reset values of the branch clock
// Assumes 12-bit APB byte addresses, one 32-bit word per register
`ifndef BRANCH_CLOCK_REGS_SVH
`define BRANCH_CLOCK_REGS_SVH
`define CFG_ADDR 12'h000
`define STAT_ADDR 12'h004
`define RUN_BIT 0
`define DRAIN_BIT 1
`define WAKE_BIT 2
`define GATE_LSB 3
`define GATE_MSB 5
`define STATE_LSB 8
`define STATE_MSB 9
`define USED_MSB 9
`define RSV_LO_MSB 7
`define RSV_LO_LSB 6
`define RUN_RESET 1'b1
`define WORD_ZERO 32'h0000_0000
`define GATE_ZERO 3'h0
`endif

/* hdl/branch_clock_pkg.sv */
// Types shared by the branch clock gate and its state machine
// Assumes nothing of its surroundings
package branch_clock_pkg;
    // Default encoding gives the status codes 00, 01, 10, 11
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_OFF_REL,
        ST_OFF_IDLE
    } ce_state_t;
endpackage

/* hdl/sync_two_ff.sv */
// Two flip-flop synchroniser for one level from outside pclk
// Assumes the input is a level held longer than two pclk periods
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // sync_two_ff
`default_nettype wire

/* hdl/branch_clock_fsm.sv */
// Clock-enable state machine with bus disable handshake
// Assumes off_dec and grant come from logic on pclk
`timescale 1ns/1ps
`default_nettype none
module branch_clock_fsm (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic off_dec,
    input wire logic drain_en,
    input wire logic grant,
    output branch_clock_pkg::ce_state_t state_r,
    output logic off_req_r
);
    branch_clock_pkg::ce_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            branch_clock_pkg::ST_RUN: begin
                if (off_dec && drain_en) begin
                    state_nxt = branch_clock_pkg::ST_WAIT;
                end else if (off_dec) begin
                    state_nxt = branch_clock_pkg::ST_OFF_IDLE;
                end
            end
            branch_clock_pkg::ST_WAIT: begin
                if (!off_dec) begin
                    state_nxt = branch_clock_pkg::ST_RUN;
                end else if (grant) begin
                    state_nxt = branch_clock_pkg::ST_OFF_REL;
                end
            end
            branch_clock_pkg::ST_OFF_REL: begin
                if (!off_dec) begin
                    state_nxt = branch_clock_pkg::ST_RUN;
                end else begin
                    state_nxt = branch_clock_pkg::ST_OFF_IDLE;
                end
            end
            branch_clock_pkg::ST_OFF_IDLE: begin
                if (!off_dec) begin
                    state_nxt = branch_clock_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = branch_clock_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= branch_clock_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request is high exactly while waiting for the grant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_req_r <= 1'b0;
        end else begin
            off_req_r <= (state_nxt == branch_clock_pkg::ST_WAIT);
        end
    end
endmodule // branch_clock_fsm
`default_nettype wire

/* hdl/branch_clock_gate_status.sv */
// Branch clock gate: configuration, live status, disable handshake
// Assumes an APB master on pclk, grant from the bus master on pclk,
// wake_event from outside pclk, power-down level from logic on pclk
//
// Local design decisions: the APB slave port and the placing of the registers.
`include "branch_clock_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module branch_clock_gate_status #(
    parameter int GATE_BITS = 3,
    parameter bit WAKE_AUTO_TIED = 1'b0,
    parameter bit RUN_TIED = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_power_down,
    input wire logic wake_event,
    input wire logic bus_off_grant,
    output logic bus_off_request,
    output logic branch_clk_en
);
    localparam logic [2:0] GATE_MASK = 3'((1 << GATE_BITS) - 1);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic cfg_run_r;
    logic cfg_drain_r;
    logic cfg_wake_r;
    logic [2:0] cfg_gate_r;
    logic st_run_r;
    logic st_drain_r;
    logic st_wake_r;
    logic [2:0] st_gate_r;
    logic wake_hold_r;
    logic wake_sync;
    logic off_dec;
    logic stable;
    logic setup;
    logic done;
    logic hit_cfg;
    logic hit_stat;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    branch_clock_pkg::ce_state_t state;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign setup = psel && !penable;
    assign done = psel && penable && pready;
    assign hit_cfg = (paddr == `CFG_ADDR);
    assign hit_stat = (paddr == `STAT_ADDR);

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_run_r <= `RUN_RESET;
            cfg_drain_r <= 1'b0;
            cfg_wake_r <= 1'b0;
            cfg_gate_r <= `GATE_ZERO;
        end else if (done && pwrite && hit_cfg) begin
            cfg_run_r <= RUN_TIED | pwdata[`RUN_BIT];
            cfg_drain_r <= !WAKE_AUTO_TIED && pwdata[`DRAIN_BIT];
            cfg_wake_r <= !WAKE_AUTO_TIED && pwdata[`WAKE_BIT];
            cfg_gate_r <= pwdata[`GATE_MSB:`GATE_LSB] & GATE_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Applied control signals
    // ----------------------------------------------------------------
    // Configuration reaches the hardware only outside a handshake
    assign stable = (state == branch_clock_pkg::ST_RUN) ||
                    (state == branch_clock_pkg::ST_OFF_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_run_r <= `RUN_RESET;
            st_drain_r <= 1'b0;
            st_wake_r <= 1'b0;
            st_gate_r <= `GATE_ZERO;
        end else if (stable) begin
            st_run_r <= cfg_run_r;
            st_drain_r <= cfg_drain_r;
            st_wake_r <= cfg_wake_r;
            st_gate_r <= cfg_gate_r;
        end
    end

    // ----------------------------------------------------------------
    // Wake-up and switch-off decision
    // ----------------------------------------------------------------
    sync_two_ff u_wake_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(wake_event),
        .sync_out(wake_sync)
    );

    // A wake event holds the branch on until power-down is cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_hold_r <= 1'b0;
        end else if (wake_sync && global_power_down) begin
            wake_hold_r <= 1'b1;
        end else if (!global_power_down) begin
            wake_hold_r <= 1'b0;
        end
    end

    assign off_dec = !st_run_r ||
        (st_wake_r && global_power_down && !wake_hold_r);

    branch_clock_fsm u_fsm (
        .pclk(pclk),
        .presetn(presetn),
        .off_dec(off_dec),
        .drain_en(st_drain_r),
        .grant(bus_off_grant),
        .state_r(state),
        .off_req_r(bus_off_request)
    );

    // ----------------------------------------------------------------
    // Glitch-free clock enable
    // ----------------------------------------------------------------
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_clk_en <= 1'b1;
        end else begin
            branch_clk_en <= (state == branch_clock_pkg::ST_RUN) ||
                (state == branch_clock_pkg::ST_WAIT) ||
                (|st_gate_r);
        end
    end

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    always_comb begin
        cfg_word = `WORD_ZERO;
        cfg_word[`RUN_BIT] = cfg_run_r;
        cfg_word[`DRAIN_BIT] = cfg_drain_r;
        cfg_word[`WAKE_BIT] = cfg_wake_r;
        cfg_word[`GATE_MSB:`GATE_LSB] = cfg_gate_r;
    end

    always_comb begin
        stat_word = `WORD_ZERO;
        stat_word[`RUN_BIT] = st_run_r;
        stat_word[`DRAIN_BIT] = st_drain_r;
        stat_word[`WAKE_BIT] = st_wake_r;
        stat_word[`GATE_MSB:`GATE_LSB] = st_gate_r;
        stat_word[`STATE_MSB:`STATE_LSB] = state;
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // Every transfer completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !(hit_cfg || (hit_stat && !pwrite));
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `WORD_ZERO;
        end else if (setup && !pwrite && hit_cfg) begin
            prdata <= cfg_word;
        end else if (setup && !pwrite && hit_stat) begin
            prdata <= stat_word;
        end else if (setup) begin
            prdata <= `WORD_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_gate_absent;
        @(posedge pclk) disable iff (!presetn)
        (cfg_gate_r & ~GATE_MASK) == `GATE_ZERO &&
        (st_gate_r & ~GATE_MASK) == `GATE_ZERO;
    endproperty
    a_gate_absent: assert property (p_gate_absent)
        else $error("unimplemented override bit set");

    property p_tied_low;
        @(posedge pclk) disable iff (!presetn)
        WAKE_AUTO_TIED |-> !cfg_wake_r && !cfg_drain_r && !st_drain_r;
    endproperty
    a_tied_low: assert property (p_tied_low)
        else $error("tied-low wake or drain bit became one");

    property p_tied_high;
        @(posedge pclk) disable iff (!presetn)
        RUN_TIED |-> cfg_run_r && st_run_r;
    endproperty
    a_tied_high: assert property (p_tied_high)
        else $error("tied-high run bit became zero");

    property p_stat_zero;
        @(posedge pclk) disable iff (!presetn)
        done && !pwrite && hit_stat |->
        prdata[31:`USED_MSB+1] == 22'h00_0000 &&
        prdata[`RSV_LO_MSB:`RSV_LO_LSB] == 2'h0;
    endproperty
    a_stat_zero: assert property (p_stat_zero)
        else $error("reserved status bits not zero");

    property p_state_code;
        @(posedge pclk) disable iff (!presetn)
        done && !pwrite && hit_stat |->
        prdata[`STATE_MSB:`STATE_LSB] == $past(state) &&
        prdata[`RUN_BIT] == $past(st_run_r);
    endproperty
    a_state_code: assert property (p_state_code)
        else $error("status read does not match state");

    property p_wait_req;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_WAIT |->
        bus_off_request && branch_clk_en;
    endproperty
    a_wait_req: assert property (p_wait_req)
        else $error("wait state without request or clock");

    property p_released;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_OFF_REL && st_gate_r == `GATE_ZERO
        |-> !bus_off_request && !branch_clk_en;
    endproperty
    a_released: assert property (p_released)
        else $error("released state left clock or request on");

    property p_grant;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_WAIT && bus_off_grant && off_dec
        |=> state == branch_clock_pkg::ST_OFF_REL ##1
        state != branch_clock_pkg::ST_WAIT;
    endproperty
    a_grant: assert property (p_grant)
        else $error("grant did not release the request");

    property p_no_drain;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_RUN && off_dec && !st_drain_r
        |=> state == branch_clock_pkg::ST_OFF_IDLE && !bus_off_request;
    endproperty
    a_no_drain: assert property (p_no_drain)
        else $error("gated without drain took a handshake");

    property p_run_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(st_run_r) && state == branch_clock_pkg::ST_RUN &&
        !st_drain_r |-> ##1 state == branch_clock_pkg::ST_OFF_IDLE;
    endproperty
    a_run_clear: assert property (p_run_clear)
        else $error("clearing run did not switch off");

    property p_wake_on;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_OFF_IDLE && st_run_r &&
        !global_power_down |=> state == branch_clock_pkg::ST_RUN;
    endproperty
    a_wake_on: assert property (p_wake_on)
        else $error("power-down clear did not wake branch");

    property p_req_only_wait;
        @(posedge pclk) disable iff (!presetn)
        bus_off_request |-> state == branch_clock_pkg::ST_WAIT;
    endproperty
    a_req_only_wait: assert property (p_req_only_wait)
        else $error("disable request outside wait state");

    property p_run_clock;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_RUN |-> branch_clk_en;
    endproperty
    a_run_clock: assert property (p_run_clock)
        else $error("clock gated in run state");

    property p_off_gated;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_OFF_IDLE && st_gate_r == `GATE_ZERO
        |-> !branch_clk_en;
    endproperty
    a_off_gated: assert property (p_off_gated)
        else $error("clock running in off state without override");

    property p_override_on;
        @(posedge pclk) disable iff (!presetn)
        st_gate_r != `GATE_ZERO |-> branch_clk_en;
    endproperty
    a_override_on: assert property (p_override_on)
        else $error("override active but clock gated");

    property p_lag_hold;
        @(posedge pclk) disable iff (!presetn)
        !stable |=> $stable(st_run_r) && $stable(st_drain_r) &&
        $stable(st_wake_r);
    endproperty
    a_lag_hold: assert property (p_lag_hold)
        else $error("status moved during the handshake");

    property p_pd_ignored;
        @(posedge pclk) disable iff (!presetn)
        state == branch_clock_pkg::ST_RUN && st_run_r && !st_wake_r
        |=> state == branch_clock_pkg::ST_RUN;
    endproperty
    a_pd_ignored: assert property (p_pd_ignored)
        else $error("branch without wake left run state");

    property p_stat_write;
        @(posedge pclk) disable iff (!presetn)
        done && pwrite && !hit_cfg |-> pslverr;
    endproperty
    a_stat_write: assert property (p_stat_write)
        else $error("write to status or unmapped word not refused");
endmodule // branch_clock_gate_status
`default_nettype wire

/* tb/bus_master_model.sv */
// Behavioural bus master that grants branch clock disable requests
// Assumes request and grant are levels on pclk; delay set by the bench
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bus_off_request,
    input wire logic [7:0] grant_delay,
    output logic bus_off_grant
);
    // ------------------------------------------------------------
    // Grant after outstanding transfers have drained
    // ------------------------------------------------------------
    logic [7:0] drain_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drain_cnt_r <= 8'h00;
            bus_off_grant <= 1'b0;
        end else if (!bus_off_request) begin
            drain_cnt_r <= 8'h00;
            bus_off_grant <= 1'b0;
        end else if (drain_cnt_r >= grant_delay) begin
            bus_off_grant <= 1'b1;
        end else begin
            drain_cnt_r <= drain_cnt_r + 8'h01;
        end
    end
endmodule // bus_master_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the branch clock gate with APB access
// Assumes the design answers APB with no wait states, 40 ns clock
`include "branch_clock_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic global_power_down = 0, wake_event = 0, which = 0, req_q = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, prdata_t, rd_bus;
    logic pready, pready_t, pslverr, pslverr_t, rdy_bus, err_bus;
    logic bus_off_request, bus_off_grant, branch_clk_en, unused_req;
    logic unused_en;
    logic [7:0] grant_delay = 8'h0c;
    int fails = 0, n_compared = 0, overlaps = 0, req_rises = 0;
    int hi_changes = 0;
    always #20 pclk = ~pclk;
    assign rd_bus = which ? prdata_t : prdata;
    assign rdy_bus = which ? pready_t : pready;
    assign err_bus = which ? pslverr_t : pslverr;
    branch_clock_gate_status branch_clock_gate_status_i (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel & !which),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_power_down(global_power_down), .wake_event(wake_event),
        .bus_off_grant(bus_off_grant), .bus_off_request(bus_off_request),
        .branch_clk_en(branch_clk_en));
    branch_clock_gate_status #(.GATE_BITS(0), .WAKE_AUTO_TIED(1'b1),
        .RUN_TIED(1'b1)) tied_branch_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel & which), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_t),
        .pready(pready_t), .pslverr(pslverr_t),
        .global_power_down(global_power_down), .wake_event(wake_event),
        .bus_off_grant(1'b0), .bus_off_request(unused_req),
        .branch_clk_en(unused_en));
    bus_master_model bus_master_model_i (.pclk(pclk), .presetn(presetn),
        .bus_off_request(bus_off_request), .grant_delay(grant_delay),
        .bus_off_grant(bus_off_grant));
    // ------------------------------------------------------------
    // Monitors on the handshake and the gate enable
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        req_q <= bus_off_request;
        if (presetn && bus_off_request === 1'b1 && branch_clk_en !== 1'b1)
            overlaps++;
        if (bus_off_request === 1'b1 && req_q !== 1'b1)
            req_rises++;
    end
    always @(branch_clk_en) begin
        if (presetn && pclk !== 1'b0)
            hi_changes++;
    end
    // ------------------------------------------------------------
    // Checking, bus tasks and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rdy_bus !== 1'b1);
        rd = rd_bus;
        err = err_bus;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic e);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
        chk({31'h0000_0000, err}, {31'h0000_0000, e});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                       input logic e);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b0, 32'h0000_0000, rd, err);
        chk(rd, exp);
        chk({31'h0000_0000, err}, {31'h0000_0000, e});
    endtask
    task automatic wait_stat(input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        int n;
        n = 0;
        do begin
            apb(`STAT_ADDR, 1'b0, 32'h0000_0000, rd, err);
            n++;
        end while (rd[9:8] !== exp[9:8] && n < 40);
        chk(rd, exp);
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        report_and_stop;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`STAT_ADDR, 32'h0000_0001, 1'b0);
        rdc(`CFG_ADDR, 32'h0000_0001, 1'b0);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0001);
        wr(`CFG_ADDR, 32'hffff_ffff, 1'b0);
        repeat (4) @(posedge pclk);
        rdc(`STAT_ADDR, 32'h0000_003f, 1'b0);
        wr(`CFG_ADDR, 32'h0000_0001, 1'b0);
        wr(`STAT_ADDR, 32'h0000_0000, 1'b1);
        rdc(12'h008, 32'h0000_0000, 1'b1);
        rdc(`STAT_ADDR, 32'h0000_0001, 1'b0);
        $display("test reset and map done");
        wr(`CFG_ADDR, 32'h0000_0002, 1'b0);
        wait_stat(32'h0000_0102);
        chk({31'h0000_0000, bus_off_request}, 32'h0000_0001);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0001);
        wr(`CFG_ADDR, 32'h0000_0006, 1'b0);
        rdc(`STAT_ADDR, 32'h0000_0102, 1'b0);
        wait_stat(32'h0000_0306);
        chk({31'h0000_0000, bus_off_request}, 32'h0000_0000);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0000);
        wr(`CFG_ADDR, 32'h0000_0003, 1'b0);
        wait_stat(32'h0000_0003);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0001);
        grant_delay <= 8'h00;
        wr(`CFG_ADDR, 32'h0000_0002, 1'b0);
        wait_stat(32'h0000_0302);
        wr(`CFG_ADDR, 32'h0000_0001, 1'b0);
        wait_stat(32'h0000_0001);
        chk(32'(overlaps), 32'h0000_0000);
        chk(32'(req_rises), 32'h0000_0002);
        $display("test drain handshake done");
        wr(`CFG_ADDR, 32'h0000_0000, 1'b0);
        wait_stat(32'h0000_0300);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0000);
        chk(32'(req_rises), 32'h0000_0002);
        wr(`CFG_ADDR, 32'h0000_0008, 1'b0);
        wait_stat(32'h0000_0308);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0001);
        wr(`CFG_ADDR, 32'h0000_0001, 1'b0);
        wait_stat(32'h0000_0001);
        $display("test direct gating done");
        global_power_down <= 1'b1;
        repeat (10) @(posedge pclk);
        rdc(`STAT_ADDR, 32'h0000_0001, 1'b0);
        wr(`CFG_ADDR, 32'h0000_0005, 1'b0);
        wait_stat(32'h0000_0305);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0000);
        wake_event <= 1'b1;
        wait_stat(32'h0000_0005);
        wake_event <= 1'b0;
        global_power_down <= 1'b0;
        repeat (4) @(posedge pclk);
        global_power_down <= 1'b1;
        wait_stat(32'h0000_0305);
        global_power_down <= 1'b0;
        wait_stat(32'h0000_0005);
        chk({31'h0000_0000, branch_clk_en}, 32'h0000_0001);
        $display("test power down and wake done");
        which <= 1'b1;
        wr(`CFG_ADDR, 32'h0000_0000, 1'b0);
        wr(`CFG_ADDR, 32'hffff_ffff, 1'b0);
        repeat (4) @(posedge pclk);
        rdc(`CFG_ADDR, 32'h0000_0001, 1'b0);
        rdc(`STAT_ADDR, 32'h0000_0001, 1'b0);
        chk({31'h0000_0000, unused_en}, 32'h0000_0001);
        chk({31'h0000_0000, unused_req}, 32'h0000_0000);
        which <= 1'b0;
        chk(32'(hi_changes), 32'h0000_0000);
        $display("test tied branch done");
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
